// >>> hw/ssi_pos_pkg.sv
package ssi_pos_pkg;
    localparam int clk_hz = 10_000_000;
    localparam int dir_hold_us = 1000;
    localparam int zero_hold_us = 12000;
    localparam int recovery_time_us = 20;
    localparam int extra_clock_pause_us = 0;
    localparam int dir_hold_cycles = (dir_hold_us * (clk_hz / 1_000_000)) + 1;
    localparam int zero_hold_cycles = (zero_hold_us * (clk_hz / 1_000_000)) + 1;
    localparam int recovery_cycles = recovery_time_us * (clk_hz / 1_000_000);
    localparam int pause_cycles = extra_clock_pause_us * (clk_hz / 1_000_000);
    localparam int word_single = 13;
    localparam int word_multi = 25;
    localparam int pos_w = 25;
    localparam int cnt_w = 24;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_shift = 2'b01,
        st_recover = 2'b10
    } link_state_type;

    typedef struct packed {
        logic dir_rev;
        logic zero_req;
    } prog_type;
endpackage : ssi_pos_pkg

// >>> hw/pos_fifo.sv
`timescale 1ns/1ns
module pos_fifo #(
    parameter int width = 25,
    parameter int depth = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    typedef struct packed {
        logic [aw:0] wp;
        logic [aw:0] rp;
        logic [width-1:0] dout;
        logic dvalid;
    } fifo_state_type;
    fifo_state_type s_r, s_nxt;
    logic [width-1:0] mem [depth];
    logic full, empty, wr, rd;

    assign empty = (s_r.wp == s_r.rp);
    assign full = (s_r.wp[aw] != s_r.rp[aw]) && (s_r.wp[aw-1:0] == s_r.rp[aw-1:0]);
    assign in_ready = !full;
    assign wr = in_valid && !full;
    assign rd = !empty && (!s_r.dvalid || out_ready);
    assign out_valid = s_r.dvalid;
    assign out_data = s_r.dout;

    always_comb begin
        s_nxt = s_r;
        if (wr) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (out_ready) begin
            s_nxt.dvalid = 1'b0;
        end
        if (rd) begin
            s_nxt.rp = s_r.rp + 1'b1;
            s_nxt.dout = mem[s_r.rp[aw-1:0]];
            s_nxt.dvalid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[s_r.wp[aw-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : pos_fifo

// >>> hw/prog_filter.sv
`timescale 1ns/1ns
module prog_filter #(
    parameter int hold_cycles = 10001
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic held
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [23:0] cnt;
        logic held;
    } filt_state_type;
    filt_state_type s_r, s_nxt;
    localparam logic [23:0] hold_max = 24'(hold_cycles);

    assign held = s_r.held;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin;
        s_nxt.s2 = s_r.s1;
        if (!s_r.s2) begin
            s_nxt.cnt = '0;
            s_nxt.held = 1'b0;
        end else if (s_r.cnt < hold_max) begin
            s_nxt.cnt = s_r.cnt + 24'h000001;
        end else begin
            s_nxt.held = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : prog_filter

// >>> hw/ssi_position_out.sv
`timescale 1ns/1ns
module ssi_position_out #(
    parameter bit multiturn = 1'b1,
    parameter int dir_hold = ssi_pos_pkg::dir_hold_cycles,
    parameter int zero_hold = ssi_pos_pkg::zero_hold_cycles,
    parameter int recovery = ssi_pos_pkg::recovery_cycles,
    parameter int pause = ssi_pos_pkg::pause_cycles,
    parameter int fifo_depth = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ssi_pos_pkg::pos_w-1:0] pos_in,
    input wire logic pos_valid,
    output logic pos_ready,
    input wire logic link_clk,
    output logic link_data,
    input wire logic dir_pin,
    input wire logic zero_pin,
    output logic dir_reversed
);
    localparam int word_len = multiturn ? ssi_pos_pkg::word_multi : ssi_pos_pkg::word_single;
    localparam logic [4:0] last_bit = 5'(word_len - 1);
    // last bit stands for half the recovery time so a late reader still sees it
    localparam logic [23:0] lsb_hold = 24'(recovery / 2);
    localparam logic [23:0] rec_cnt = 24'(recovery);
    localparam logic [23:0] quiet_cnt = 24'(recovery + pause);
    localparam int pw = ssi_pos_pkg::pos_w;

    // ****************************************
    // programming inputs
    // ****************************************
    ssi_pos_pkg::prog_type prog;
    prog_filter #(.hold_cycles(dir_hold)) u_dir (
        .clk(clk),
        .rst(rst),
        .pin(dir_pin),
        .held(prog.dir_rev)
    );
    prog_filter #(.hold_cycles(zero_hold)) u_zero (
        .clk(clk),
        .rst(rst),
        .pin(zero_pin),
        .held(prog.zero_req)
    );

    // ****************************************
    // position stream
    // ****************************************
    logic f_valid;
    logic [pw-1:0] f_data;
    pos_fifo #(.width(pw), .depth(fifo_depth)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(pos_valid),
        .in_ready(pos_ready),
        .in_data(pos_in),
        .out_valid(f_valid),
        .out_ready(1'b1),
        .out_data(f_data)
    );

    typedef struct packed {
        logic c1;
        logic c2;
        logic c3;
        ssi_pos_pkg::link_state_type st;
        logic [pw-1:0] raw;
        logic [pw-1:0] offset;
        logic zero_seen;
        logic [pw-1:0] word;
        logic [4:0] idx;
        logic data;
        logic [23:0] hi_cnt;
        logic fresh;
    } out_state_type;
    out_state_type s_r, s_nxt;

    logic [pw-1:0] rel, dirpos, gray;
    logic clk_fall, clk_rise;

    assign clk_fall = s_r.c3 && !s_r.c2;
    assign clk_rise = !s_r.c3 && s_r.c2;
    assign rel = s_r.raw - s_r.offset;
    assign dirpos = prog.dir_rev ? pw'(-rel) : rel;
    assign gray = dirpos ^ (dirpos >> 1);
    assign link_data = s_r.data;
    assign dir_reversed = prog.dir_rev;

    // ****************************************
    // link state machine
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.c1 = link_clk;
        s_nxt.c2 = s_r.c1;
        s_nxt.c3 = s_r.c2;
        if (f_valid) begin
            s_nxt.raw = f_data;
        end
        s_nxt.zero_seen = prog.zero_req;
        if (prog.zero_req && !s_r.zero_seen) begin
            s_nxt.offset = s_r.raw;
        end
        if (!s_r.c2) begin
            s_nxt.hi_cnt = '0;
        end else if (s_r.c2 && s_r.hi_cnt != 24'hffffff) begin
            s_nxt.hi_cnt = s_r.hi_cnt + 24'h000001;
        end
        case (s_r.st)
            ssi_pos_pkg::st_idle: begin
                s_nxt.data = 1'b1;
                if (clk_fall) begin
                    if (s_r.fresh) begin
                        s_nxt.word = gray;
                    end
                    s_nxt.idx = last_bit;
                    s_nxt.st = ssi_pos_pkg::st_shift;
                end
            end
            ssi_pos_pkg::st_shift: begin
                if (clk_rise) begin
                    s_nxt.data = s_r.word[s_r.idx];
                    if (s_r.idx == '0) begin
                        s_nxt.st = ssi_pos_pkg::st_recover;
                    end else begin
                        s_nxt.idx = s_r.idx - 5'h01;
                    end
                end else if (s_r.hi_cnt >= rec_cnt) begin
                    s_nxt.fresh = 1'b1;
                    s_nxt.st = ssi_pos_pkg::st_idle;
                end
            end
            default: begin
                if (s_r.hi_cnt >= rec_cnt) begin
                    s_nxt.data = 1'b1;
                end else if (s_r.hi_cnt >= lsb_hold) begin
                    s_nxt.data = 1'b0;
                end
                if (clk_fall) begin
                    if (s_r.hi_cnt < rec_cnt) begin
                        s_nxt.data = 1'b0;
                    end
                    if (s_r.hi_cnt >= quiet_cnt) begin
                        s_nxt.word = gray;
                        s_nxt.fresh = 1'b1;
                    end else begin
                        s_nxt.fresh = 1'b0;
                    end
                    s_nxt.idx = last_bit;
                    s_nxt.st = ssi_pos_pkg::st_shift;
                end else if (s_r.hi_cnt >= quiet_cnt) begin
                    s_nxt.fresh = 1'b1;
                    s_nxt.st = ssi_pos_pkg::st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{c1: 1'b1, c2: 1'b1, c3: 1'b1, st: ssi_pos_pkg::st_idle,
                     data: 1'b1, fresh: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_idle_data_high: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ssi_pos_pkg::st_idle) |=> link_data)
        else $error("data not high in idle");
    chk_capture_on_fall: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ssi_pos_pkg::st_idle && clk_fall && s_r.fresh) |=> (s_r.word == $past(gray)))
        else $error("word not captured on falling edge");
    chk_first_bit_msb: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ssi_pos_pkg::st_shift && clk_rise && s_r.idx == last_bit)
        |=> (link_data == $past(s_r.word[last_bit])))
        else $error("first bit is not msb");
    chk_recover_low: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ssi_pos_pkg::st_recover && !clk_fall && s_r.hi_cnt >= lsb_hold
         && s_r.hi_cnt < rec_cnt) |=> !link_data)
        else $error("data not low in recovery");
    chk_repeat_word: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ssi_pos_pkg::st_recover && clk_fall && s_r.hi_cnt < quiet_cnt)
        |=> $stable(s_r.word) && !s_r.fresh)
        else $error("word changed on early reclock");
    chk_fresh_after_rest: assert property (@(posedge clk) disable iff (rst)
        (s_r.st == ssi_pos_pkg::st_recover && s_r.hi_cnt >= quiet_cnt) |=> s_r.fresh)
        else $error("no fresh capture after rest");
    chk_gray_code: assert property (@(posedge clk) disable iff (rst)
        ((^gray) == dirpos[0]) && (gray[pw-1] == dirpos[pw-1]))
        else $error("gray code mismatch");
    chk_zero_offset: assert property (@(posedge clk) disable iff (rst)
        (prog.zero_req && !s_r.zero_seen) |=> (s_r.offset == $past(s_r.raw)))
        else $error("zeroing did not load offset");
endmodule : ssi_position_out

// >>> tb/ssi_ctrl_model.sv
`timescale 1ns/1ns
module ssi_ctrl_model #(
    // wait after the last bit, inside the low recovery window of the bench's timing
    parameter int tail_ns = 2600
) (
    output logic link_clk,
    input wire logic link_data
);
    // ****************************************
    // controller: clock generator and reader
    // ****************************************
    initial begin
        link_clk = 1'b1;
    end

    // own delays keep this clock unrelated in phase to the system clock
    task automatic read_word(input int nbits, output logic [31:0] word, output logic tail);
        word = '0;
        #37;
        for (int k = 0; k < nbits; k++) begin
            link_clk = 1'b0;
            #400;
            if (k > 0) word = {word[30:0], link_data};
            link_clk = 1'b1;
            #400;
        end
        word = {word[30:0], link_data};
        #tail_ns;
        tail = link_data;
    endtask : read_word
endmodule : ssi_ctrl_model

// >>> tb/ssi_absolute_position_output_tb_top.sv
`timescale 1ns/1ns
module ssi_absolute_position_output_tb_top;
    // ****************
    // bench signals
    // ****************
    localparam int hold = 20;
    localparam int rec = 40;
    logic clk;
    logic rst;
    logic [ssi_pos_pkg::pos_w-1:0] pos_in;
    logic pos_valid;
    logic pos_ready;
    logic link_clk;
    logic link_data;
    logic dir_pin;
    logic zero_pin;
    logic dir_reversed;
    int err_total;
    int num_checks;
    int cycles = 0;
    logic [24:0] raw;
    logic [24:0] off;
    logic rev;
    logic [31:0] word;
    logic [31:0] prev;
    logic tail;

    ssi_position_out #(.multiturn(1'b1), .dir_hold(hold), .zero_hold(hold), .recovery(rec),
        .pause(0), .fifo_depth(32)) i_dut (
        .clk(clk), .rst(rst), .pos_in(pos_in), .pos_valid(pos_valid), .pos_ready(pos_ready),
        .link_clk(link_clk), .link_data(link_data), .dir_pin(dir_pin), .zero_pin(zero_pin),
        .dir_reversed(dir_reversed));
    ssi_ctrl_model i_ctrl (.link_clk(link_clk), .link_data(link_data));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            finish_test();
        end
    end

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] exp_word(input logic [24:0] p, input logic [24:0] o,
        input logic r);
        logic [24:0] v;
        v = p - o;
        if (r) v = -v;
        return {7'h00, v ^ (v >> 1)};
    endfunction : exp_word

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic push(input logic [24:0] p);
        @(posedge clk);
        pos_in <= p;
        pos_valid <= 1'b1;
        @(posedge clk);
        pos_valid <= 1'b0;
        raw = p;
        repeat (10) @(posedge clk);
    endtask : push

    task automatic frame(input logic [31:0] exp);
        i_ctrl.read_word(ssi_pos_pkg::word_multi, word, tail);
        check(word, exp);
        check({31'h0, tail}, 32'h0);
    endtask : frame

    task automatic rest();
        repeat (rec + 10) @(posedge clk);
        @(negedge clk);
        check({31'h0, link_data}, 32'h1);
    endtask : rest

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ****************
    // main sequence
    // ****************
    initial begin
        rst = 1'b1;
        pos_in = '0;
        pos_valid = 1'b0;
        dir_pin = 1'b0;
        zero_pin = 1'b0;
        err_total = 0;
        num_checks = 0;
        off = '0;
        rev = 1'b0;
        raw = '0;
        void'($urandom(32'h657596e7));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({31'h0, link_data}, 32'h1);
        check({31'h0, pos_ready}, 32'h1);
        check({31'h0, dir_reversed}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            push(i == 0 ? 25'h0 : i == 1 ? 25'h1ffffff : 25'($urandom));
            frame(exp_word(raw, off, rev));
            rest();
        end
        $display("test random words done");
        push(25'h0aaaaaa);
        prev = exp_word(raw, off, rev);
        frame(prev);
        fork
            frame(prev);
            begin
                repeat (10) @(posedge clk);
                push(25'h1555555);
            end
        join
        rest();
        frame(exp_word(raw, off, rev));
        rest();
        $display("test repeat and recapture done");
        @(posedge clk);
        zero_pin <= 1'b1;
        repeat (hold + 20) @(posedge clk);
        zero_pin <= 1'b0;
        off = raw;
        frame(32'h0);
        rest();
        push(raw + 25'h5);
        frame(exp_word(raw, off, rev));
        rest();
        $display("test zeroing done");
        @(posedge clk);
        dir_pin <= 1'b1;
        repeat (hold - 5) @(posedge clk);
        dir_pin <= 1'b0;
        repeat (10) @(negedge clk);
        check({31'h0, dir_reversed}, 32'h0);
        @(posedge clk);
        dir_pin <= 1'b1;
        repeat (hold + 10) @(negedge clk);
        check({31'h0, dir_reversed}, 32'h1);
        rev = 1'b1;
        frame(exp_word(raw, off, rev));
        rest();
        @(posedge clk);
        dir_pin <= 1'b0;
        repeat (10) @(negedge clk);
        check({31'h0, dir_reversed}, 32'h0);
        $display("test direction done");
        rev = 1'b0;
        push(25'($urandom));
        i_ctrl.read_word(5, word, tail);
        check(word, exp_word(raw, off, rev) >> 20);
        rest();
        push(25'($urandom));
        frame(exp_word(raw, off, rev));
        rest();
        $display("test interrupted transfer done");
        finish_test();
    end
endmodule : ssi_absolute_position_output_tb_top
